// >>> bench/ddr_sdram_command_timing_test.sv
// self-checking bench for the ddr command front end
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, want) begin num_checks++; if ((got) !== (want)) begin bad_count++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, want); end end
module ddr_sdram_command_timing_test;
    import ddrct_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic module_reset_n = 1'b1;
    ddrct_pins_t pins;
    ddrct_dec_t dec;
    ddrct_stat_t stat;
    logic [ROW_W-1:0] open_row [NUM_BANKS];
    int bad_count = 0;
    int num_checks = 0;

    always #2.5 core_clk = ~core_clk;
    ddrct_ctrl_model ctrl (.core_clk(core_clk), .pins(pins));
    ddrct_top uut (.core_clk(core_clk), .rst(rst), .module_reset_n(module_reset_n), .pins(pins), .dec(dec),
        .stat(stat), .open_row(open_row));

    // bank b goes out as hi = b[0], lo = b[1]
    task automatic issue(input logic cs_n, input logic [2:0] rcw, input logic cke, input logic [1:0] b,
                         input logic [12:0] a, input ddrct_cmd_t want, input logic seen);
        int n;
        n = 0;
        ctrl.send(cs_n, rcw, cke, {b[0], b[1]}, a);
        while (dec.cmd_valid !== 1'b1 && n < 6) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(dec.cmd_valid, seen)
        if (seen) `CHK(dec.cmd, want)
    endtask

    task automatic t_codes();
        logic [2:0] rcw [7] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h2, 3'h1, 3'h0};
        ddrct_cmd_t want [7] = '{DDRCT_ACT, DDRCT_WR, DDRCT_RD, DDRCT_BST, DDRCT_PRE, DDRCT_REF, DDRCT_MRS};
        for (int i = 0; i < 7; i++) issue(1'b0, rcw[i], 1'b1, 2'h0, 13'h0000, want[i], 1'b1);
    endtask

    task automatic t_banks();
        for (int b = 0; b < 4; b++) begin
            issue(1'b0, 3'h3, 1'b1, 2'(b), 13'h1A5A ^ 13'(b), DDRCT_ACT, 1'b1);
            `CHK(dec.bank, 2'(b))
            `CHK(open_row[b], 13'h1A5A ^ 13'(b))
            `CHK(stat.bank_open[b], 1'b1)
        end
    endtask

    task automatic t_access();
        issue(1'b0, 3'h5, 1'b1, 2'h1, 13'h0C05, DDRCT_RD, 1'b1);
        `CHK({dec.col, dec.auto_precharge}, 12'h80B)
        issue(1'b0, 3'h4, 1'b1, 2'h2, 13'h13FA, DDRCT_WR, 1'b1);
        `CHK({dec.col, dec.auto_precharge}, 12'h7F4)
        `CHK(stat.bank_open, 4'hD)
    endtask

    task automatic t_cs_pre();
        issue(1'b1, 3'h3, 1'b1, 2'h1, 13'h0000, DDRCT_ACT, 1'b0);
        `CHK(stat.bank_open, 4'hD)
        issue(1'b0, 3'h2, 1'b1, 2'h3, 13'h0000, DDRCT_PRE, 1'b1);
        `CHK({dec.precharge_mask, stat.bank_open}, 8'h85)
        issue(1'b0, 3'h2, 1'b1, 2'h0, 13'h0400, DDRCT_PRE, 1'b1);
        `CHK({dec.precharge_mask, stat.bank_open}, 8'hF0)
    endtask

    task automatic t_power();
        issue(1'b0, 3'h7, 1'b0, 2'h0, 13'h0000, DDRCT_PDN, 1'b1);
        `CHK(stat.power_down, 1'b1)
        issue(1'b0, 3'h3, 1'b0, 2'h0, 13'h0000, DDRCT_ACT, 1'b0);
        issue(1'b0, 3'h7, 1'b1, 2'h0, 13'h0000, DDRCT_NOP, 1'b0);
        `CHK({stat.power_down, stat.bank_open}, 5'h00)
        issue(1'b0, 3'h1, 1'b0, 2'h0, 13'h0000, DDRCT_SREF, 1'b1);
        `CHK(stat.self_refresh, 1'b1)
        issue(1'b0, 3'h7, 1'b1, 2'h0, 13'h0000, DDRCT_NOP, 1'b0);
        `CHK({stat.self_refresh, stat.read_ready}, 2'h0)
        repeat (XSRD_CYC - 4) @(negedge core_clk);
        `CHK(stat.read_ready, 1'b0)
        repeat (4) @(negedge core_clk);
        `CHK(stat.read_ready, 1'b1)
    endtask

    task automatic t_modreset();
        issue(1'b0, 3'h3, 1'b1, 2'h2, 13'h0777, DDRCT_ACT, 1'b1);
        @(posedge core_clk);
        module_reset_n <= 1'b0;
        repeat (6) @(negedge core_clk);
        `CHK({stat, open_row[2]}, 20'h00000)
        @(posedge core_clk);
        module_reset_n <= 1'b1;
        repeat (4) @(negedge core_clk);
        issue(1'b0, 3'h3, 1'b1, 2'h1, 13'h0001, DDRCT_ACT, 1'b1);
    endtask

    task automatic finish_test();
        if (bad_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_codes();
        t_banks();
        t_access();
        t_cs_pre();
        t_power();
        t_modreset();
        finish_test();
    end

    // ample margin over the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        finish_test();
    end
endmodule // ddr_sdram_command_timing_test
`default_nettype wire

// >>> bench/ddrct_ctrl_model.sv
// controller model: turns bench requests into command pin levels
`timescale 1ns/10ps
`default_nettype none
module ddrct_ctrl_model (
    input wire logic core_clk,
    output var ddrct_pkg::ddrct_pins_t pins
);
    import ddrct_pkg::*;

    // spacings owed to the module, in whole 5 ns cycles, rounded up
    localparam int MRD_CYC = 3; // 15 ns
    localparam int RC_CYC = 13; // 65 ns, covers 45/20/15 ns too
    localparam int RFC_CYC = 15; // 75 ns, also self-refresh exit
    localparam int DAL_CYC = 7; // 35 ns, covers 15 ns and one cycle too
    localparam int RP_CYC = 4; // 20 ns
    // runs stay far below one refresh interval and any open limit: none owed
    // no strobe or data lines here; strobe placement and latency stay with the data path
    int gap = 0;
    logic last_cke = 1'b1;

    initial pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 13'h0000};

    // one command cycle; clock enable keeps its new level afterwards
    task automatic send(input logic cs_n, input logic [2:0] rcw, input logic cke, input logic [1:0] bsel,
                        input logic [12:0] a);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        pins <= '{cs_n, rcw[2], rcw[1], rcw[0], cke, bsel[1], bsel[0], a};
        // wait owed before the next command depends on this one
        if (cke && !last_cke) gap = RFC_CYC;
        else if (cs_n || !cke) gap = 0;
        else begin
            case (rcw)
                3'b000: gap = MRD_CYC;
                3'b011: gap = RC_CYC;
                3'b001: gap = RFC_CYC;
                3'b100: gap = DAL_CYC;
                3'b010: gap = RP_CYC;
                default: gap = 0;
            endcase
        end
        last_cke = cke;
        @(posedge core_clk);
        // deselected: bank and address lines show the inverse, never a stale copy
        pins <= '{1'b1, 1'b1, 1'b1, 1'b1, cke, ~bsel[1], ~bsel[0], ~a};
    endtask
endmodule // ddrct_ctrl_model
`default_nettype wire

// >>> bench/ddrct_top_assertions.sv
// checker: port-level assertions for the ddr command front end
`timescale 1ns/10ps
`default_nettype none
module ddrct_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic module_reset_n,
    input wire ddrct_pkg::ddrct_pins_t pins,
    input wire ddrct_pkg::ddrct_dec_t dec,
    input wire ddrct_pkg::ddrct_stat_t stat
);
    import ddrct_pkg::*;
    logic rw;
    logic banked;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    assign rw = dec.cmd_valid && (dec.cmd == DDRCT_RD || dec.cmd == DDRCT_WR);
    assign banked = rw || (dec.cmd_valid && (dec.cmd == DDRCT_ACT || dec.cmd == DDRCT_PRE));

    a_row_capture: assert property (dec.cmd_valid && dec.cmd == DDRCT_ACT |-> dec.row == $past(pins.addr, 3))
        else $error("row differs");
    a_col_capture: assert property (rw |-> dec.col == {$past(pins.addr[11], 3), $past(pins.addr[9:0], 3)})
        else $error("column differs");
    a_auto_pre: assert property (rw |-> dec.auto_precharge == $past(pins.addr[10], 3))
        else $error("auto precharge differs");
    a_bank_decode: assert property (banked |-> dec.bank == {$past(pins.bank_select_lo, 3),
        $past(pins.bank_select_hi, 3)} && dec.bank_onehot == (4'h1 << dec.bank))
        else $error("bank decode differs");
    a_pre_mask: assert property (dec.cmd_valid && dec.cmd == DDRCT_PRE |->
        dec.precharge_all == $past(pins.addr[10], 3) && dec.precharge_mask == (dec.precharge_all ? 4'hF : dec.bank_onehot))
        else $error("precharge mask differs");
    a_pre_closes: assert property (dec.cmd_valid && dec.cmd == DDRCT_PRE |-> (stat.bank_open & dec.precharge_mask) == 4'h0)
        else $error("precharged bank open");
    a_cs_ignore: assert property (dec.cmd_valid && dec.cmd != DDRCT_PDN |-> !$past(pins.chip_select_n, 3))
        else $error("deselected command taken");
    a_sref_entry: assert property (dec.cmd_valid && dec.cmd == DDRCT_SREF |-> stat.self_refresh && !$past(pins.clock_enable, 3))
        else $error("self refresh entry wrong");
    a_pdn_entry: assert property (dec.cmd_valid && dec.cmd == DDRCT_PDN |-> stat.power_down && !$past(pins.clock_enable, 3))
        else $error("power down entry wrong");
    a_reset_clear: assert property (!module_reset_n [*5] |-> stat == 7'h00 && !dec.cmd_valid)
        else $error("module reset left state");

    cover property (dec.cmd_valid && dec.cmd == DDRCT_SREF);
    cover property (dec.cmd_valid && dec.cmd == DDRCT_PRE && dec.precharge_all);
    cover property (rw && dec.auto_precharge);
endmodule // ddrct_checker
bind ddrct_top ddrct_checker chk (.core_clk(core_clk), .rst(rst), .module_reset_n(module_reset_n), .pins(pins),
    .dec(dec), .stat(stat));
`default_nettype wire

// >>> hdl/ddrct_bank_decode.sv
// bank-select decode to one-hot bank and precharge mask
`timescale 1ns/10ps
`default_nettype none
module ddrct_bank_decode (
    input wire logic bank_select_hi,
    input wire logic bank_select_lo,
    input wire logic precharge_all,
    output logic [1:0] bank,
    output logic [ddrct_pkg::NUM_BANKS-1:0] bank_onehot,
    output logic [ddrct_pkg::NUM_BANKS-1:0] precharge_mask
);
    import ddrct_pkg::*;

    // upper pin is the low bit of the bank number
    assign bank = {bank_select_lo, bank_select_hi};

    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : g_bank
            assign bank_onehot[g] = (bank == 2'(g));
            assign precharge_mask[g] = precharge_all | bank_onehot[g];
        end
    endgenerate
endmodule // ddrct_bank_decode
`default_nettype wire

// >>> hdl/ddrct_pkg.sv
// package: constants and carrier types for the ddr command decode block
package ddrct_pkg;

    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int ROW_W = 13;
    localparam int COL_W = 11;
    localparam int NUM_BANKS = 4;
    localparam int PRECHARGE_SELECT_POS = 10;
    localparam int COL_LOW_MSB = 9;
    localparam int COL_HIGH_POS = 11;
    localparam int CLK_PERIOD_PS = 5000;
    // self-refresh exit: read allowed only after this many master clock cycles
    localparam int XSRD_CYC = 200;
    localparam logic [7:0] XSRD_CNT = 8'(XSRD_CYC);

    // ------------------------------------------------------------
    // commands
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        DDRCT_NOP = 4'h0,
        DDRCT_ACT = 4'h1,
        DDRCT_RD = 4'h2,
        DDRCT_WR = 4'h3,
        DDRCT_PRE = 4'h4,
        DDRCT_REF = 4'h5,
        DDRCT_SREF = 4'h6,
        DDRCT_MRS = 4'h7,
        DDRCT_BST = 4'h8,
        DDRCT_PDN = 4'h9
    } ddrct_cmd_t;

    // power state machine, gray along idle->pdn/sref->idle
    typedef enum logic [1:0] {
        DDRCT_ST_ACTIVE = 2'b00,
        DDRCT_ST_PDOWN = 2'b01,
        DDRCT_ST_SREF = 2'b10
    } ddrct_pwr_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic chip_select_n;
        logic row_strobe_n;
        logic col_strobe_n;
        logic write_enable_n;
        logic clock_enable;
        logic bank_select_hi;
        logic bank_select_lo;
        logic [12:0] addr;
    } ddrct_pins_t;

    typedef struct packed {
        ddrct_cmd_t cmd;
        logic cmd_valid;
        logic [1:0] bank;
        logic [NUM_BANKS-1:0] bank_onehot;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic auto_precharge;
        logic precharge_all;
        logic [NUM_BANKS-1:0] precharge_mask;
    } ddrct_dec_t;

    typedef struct packed {
        logic [NUM_BANKS-1:0] bank_open;
        logic power_down;
        logic self_refresh;
        logic read_ready;
    } ddrct_stat_t;

endpackage : ddrct_pkg

// >>> hdl/ddrct_top.sv
// registered command front end of a ddr module: decode, bank state, power modes
// ------------------------------------------------------------
// What this block does
// - chip-select high ignores command, bank and address inputs (clock-enable still acts), operations continue
// - precharge all banks when select bit high
// - select bit high on read/write enables auto-precharge
// - bank pins decode to banks zero to three
// - capture row on activate, column on access
// - clock-enable low enters power-down/self-refresh, high exits
// - commands sampled on rising master_clock edges
// - module reset clears state and output registers; the input synchroniser stages are cleared only by rst
// ------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module ddrct_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic module_reset_n,
    input wire ddrct_pkg::ddrct_pins_t pins,
    output var ddrct_pkg::ddrct_dec_t dec,
    output var ddrct_pkg::ddrct_stat_t stat,
    output logic [ddrct_pkg::ROW_W-1:0] open_row [ddrct_pkg::NUM_BANKS]
);
    import ddrct_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers (pins are off-domain)
    // ------------------------------------------------------------
    ddrct_pins_t pins_meta;
    ddrct_pins_t pins_s;
    logic rstn_meta;
    logic rstn_s;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pins_meta <= '0;
            pins_s <= '0;
            rstn_meta <= 1'b0;
            rstn_s <= 1'b0;
        end else begin
            pins_meta <= pins;
            pins_s <= pins_meta;
            rstn_meta <= module_reset_n;
            rstn_s <= rstn_meta;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        ddrct_dec_t dec;
        ddrct_pwr_t pwr;
        logic [NUM_BANKS-1:0] bank_open;
        logic [NUM_BANKS-1:0][ROW_W-1:0] rows;
        logic [7:0] xsrd;
    } ddrct_state_t;

    ddrct_state_t state;
    ddrct_state_t next_state;

    logic [1:0] bank;
    logic [NUM_BANKS-1:0] bank_onehot;
    logic [NUM_BANKS-1:0] precharge_mask;
    logic precharge_bit;

    assign precharge_bit = pins_s.addr[PRECHARGE_SELECT_POS];

    ddrct_bank_decode u_bank (
        .bank_select_hi(pins_s.bank_select_hi),
        .bank_select_lo(pins_s.bank_select_lo),
        .precharge_all(precharge_bit),
        .bank(bank),
        .bank_onehot(bank_onehot),
        .precharge_mask(precharge_mask)
    );

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    ddrct_cmd_t cmd;
    always_comb begin
        // ras/cas/we low-true levels, customary table
        case ({pins_s.row_strobe_n, pins_s.col_strobe_n, pins_s.write_enable_n})
            3'b011: cmd = DDRCT_ACT;
            3'b101: cmd = DDRCT_RD;
            3'b100: cmd = DDRCT_WR;
            3'b010: cmd = DDRCT_PRE;
            3'b001: cmd = DDRCT_REF;
            3'b000: cmd = DDRCT_MRS;
            3'b110: cmd = DDRCT_BST;
            default: cmd = DDRCT_NOP;
        endcase
    end

    always_comb begin
        logic selected;
        selected = 1'b0;
        next_state = state;
        next_state.dec.cmd_valid = 1'b0;
        next_state.dec.cmd = DDRCT_NOP;
        next_state.xsrd = (state.xsrd != 8'h00) ? state.xsrd - 8'h01 : 8'h00;
        // deselect blocks new commands except power-down entry; open banks stay open
        selected = !pins_s.chip_select_n;
        case (state.pwr)
            DDRCT_ST_ACTIVE: begin
                if (!pins_s.clock_enable) begin
                    // clock-enable low: refresh command means self-refresh
                    if (selected && cmd == DDRCT_REF) begin
                        next_state.pwr = DDRCT_ST_SREF;
                        next_state.dec.cmd = DDRCT_SREF;
                        next_state.dec.cmd_valid = 1'b1;
                    end else begin
                        next_state.pwr = DDRCT_ST_PDOWN;
                        next_state.dec.cmd = DDRCT_PDN;
                        next_state.dec.cmd_valid = 1'b1;
                    end
                end else if (selected && cmd != DDRCT_NOP) begin
                    next_state.dec.cmd = cmd;
                    next_state.dec.cmd_valid = 1'b1;
                    next_state.dec.bank = bank;
                    next_state.dec.bank_onehot = bank_onehot;
                    case (cmd)
                        DDRCT_ACT: begin
                            next_state.dec.row = pins_s.addr;
                            next_state.bank_open = state.bank_open | bank_onehot;
                            next_state.rows[bank] = pins_s.addr;
                        end
                        DDRCT_RD, DDRCT_WR: begin
                            next_state.dec.col = {pins_s.addr[COL_HIGH_POS], pins_s.addr[COL_LOW_MSB:0]};
                            next_state.dec.auto_precharge = precharge_bit;
                            if (precharge_bit) begin
                                next_state.bank_open = state.bank_open & ~bank_onehot;
                            end
                        end
                        DDRCT_PRE: begin
                            next_state.dec.precharge_all = precharge_bit;
                            next_state.dec.precharge_mask = precharge_mask;
                            next_state.bank_open = state.bank_open & ~precharge_mask;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            DDRCT_ST_PDOWN: begin
                if (pins_s.clock_enable) begin
                    next_state.pwr = DDRCT_ST_ACTIVE;
                end
            end
            DDRCT_ST_SREF: begin
                if (pins_s.clock_enable) begin
                    next_state.pwr = DDRCT_ST_ACTIVE;
                    // reads held off while the internal clocking resettles
                    next_state.xsrd = XSRD_CNT;
                end
            end
            default: next_state.pwr = DDRCT_ST_ACTIVE;
        endcase
        if (!rstn_s) begin
            next_state = '0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic [NUM_BANKS-1:0] open_r;
    logic pd_r;
    logic sr_r;
    logic rr_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            open_r <= '0;
            pd_r <= 1'b0;
            sr_r <= 1'b0;
            rr_r <= 1'b0;
        end else begin
            open_r <= next_state.bank_open;
            pd_r <= (next_state.pwr == DDRCT_ST_PDOWN);
            sr_r <= (next_state.pwr == DDRCT_ST_SREF);
            // cleared state decodes as active and idle, so module reset must mask it
            rr_r <= rstn_s && (next_state.pwr == DDRCT_ST_ACTIVE) && (next_state.xsrd == 8'h00);
        end
    end

    assign dec = state.dec;
    assign stat = '{bank_open: open_r, power_down: pd_r, self_refresh: sr_r, read_ready: rr_r};

    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : g_row
            assign open_row[g] = state.rows[g];
        end
    endgenerate
endmodule // ddrct_top
`default_nettype wire
